// ### verilog/tms_monitor.sv
// Purpose: Register file, conversion scheduler and serial-bus slave of a temperature monitor.
// Assumes: scl and sda inputs are synchronous to clk; measurements arrive as bytes.
// Notes:   Pins that drive low take an active-low output enable.
// Functional notes
// R01: Config bit 6 set means standby, clear means continuous conversion.
// R02: Standby pin low forces standby regardless of configuration.
// R03: Value registers hold their contents throughout standby.
// R04: Config bit 7 clear enables alarm output, set disables it.
// R05: Rate code low bits multiply base period by one to 128; the code multiplies the base period by 128 (code 0) down to one (code 7).
// R06: Host writes zero upper rate bits and avoids reserved codes.
// R07: High alarm on strictly greater, low alarm on strictly less.
// R08: Signed offset is added to remote reading before storage and compare.
// R09: One-shot write in software standby runs one conversion, data ignored.
// R10: Slave address comes from two three-level straps, nine addresses.
// R11: Straps are latched once after reset and then ignored.
// R12: Device shifts in seven address bits and a direction bit.
// R13: Matching address is acknowledged on ninth clock, else idle until start.
// R14: Direction zero is write, one is read.
// R15: Each byte is eight data bits plus one acknowledge.
// R16: Master changes data only while the clock is low.
// R17: Master ends a read with a not-acknowledge and a stop.
// R18: Direction changes need a new start and address.
// R19: Writes carry one or two bytes, reads exactly one.
// R20: First write byte loads pointer, second writes selected register.
// R21: Reads return the register selected by the current pointer.
// R22: Read and write addresses of a register differ; the offset register uses 11 for both.
// R23: One-shot trigger is decoded at write address 0f.
// R24: Setting the mask bit suppresses current and future alarms.
// R25: Alarm asserts while any limit flag or open-sensor flag is set.
// R26: Pointer has no defined reset value.
// R27: Run mode converts once per programmed period and re-evaluates limits.
// R28: Reserved configuration bits read zero and ignore writes.
`timescale 1ns/10ps
module tms_monitor #(
   parameter int BaseCyc = tms_pkg::BASE_CYC
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       resetn,
   // Serial bus.
   input  wire logic       scl,
   input  wire logic       serialDataLineIn,
   output logic            serialDataLineOut,
   output logic            serialDataLineOeN,
   // Straps and standby.
   input  wire logic [1:0] addrStrapLow,
   input  wire logic [1:0] addrStrapHigh,
   input  wire logic       standbyPinN,
   // Measurement front end.
   input  wire logic [7:0] localTemp,
   input  wire logic [7:0] remoteTemp,
   input  wire logic       sensorOpen,
   // Alarm open-drain output.
   output logic            alarmOut,
   output logic            alarmOeN
);
   import tms_pkg::*;
   typedef enum logic [2:0] {
      TS_IDLE = 3'b000, TS_ADDR = 3'b001, TS_AACK = 3'b010, TS_WRB = 3'b011,
      TS_WACK = 3'b100, TS_RDB = 3'b101, TS_RACK = 3'b110, TS_WAIT = 3'b111
   } tms_state_e;
   function automatic logic [2:0] strapIdx(input logic [1:0] s);
      strapIdx = (s == STRAP_HIGH) ? 3'h2 : (s == STRAP_OPEN) ? 3'h1 : 3'h0;
   endfunction : strapIdx
   tms_state_e state_r, state_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [1:0] byteIdx_r, byteIdx_nxt;
   logic       sdaDrv_r, sdaDrv_nxt;
   logic       sclPrev_r, sdaPrev_r;
   logic [7:0] ptr_r, ptr_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] rate_r, rate_nxt;
   logic [7:0] lHi_r, lHi_nxt, lLo_r, lLo_nxt, rHi_r, rHi_nxt, rLo_r, rLo_nxt;
   logic [7:0] offset_r, offset_nxt;
   logic [6:0] slaveAddr_r, slaveAddr_nxt;
   logic       strapDone_r, strapDone_nxt;
   logic       oneShot, statusClr;
   logic [22:0] baseCnt_r, baseCnt_nxt;
   logic [6:0] periodCnt_r, periodCnt_nxt;
   logic [7:0] localVal_r, localVal_nxt, remoteVal_r, remoteVal_nxt;
   logic [4:0] flags_r, flags_nxt;
   logic       alarmOeN_r, alarmOeN_nxt;
   logic       sclRise, sclFall, busStart, busStop, running, baseTick, convGo;
   logic [7:0] newRemote, readByte;
   logic [4:0] tripNew, tripCur;
   assign sclRise  = scl & ~sclPrev_r;
   assign sclFall  = ~scl & sclPrev_r;
   assign busStart = scl & sclPrev_r & sdaPrev_r & ~serialDataLineIn;
   assign busStop  = scl & sclPrev_r & ~sdaPrev_r & serialDataLineIn;
   // R21 R22 pointer-selected read
   always_comb begin
      case (ptr_r)
         RD_LOCAL:  readByte = localVal_r;
         RD_REMOTE: readByte = remoteVal_r;
         RD_STATUS: readByte = {1'b0, flags_r, 2'b00};
         RD_CONFIG: readByte = cfg_r;
         RD_RATE:   readByte = rate_r;
         RD_LHI:    readByte = lHi_r;
         RD_LLO:    readByte = lLo_r;
         RD_RHI:    readByte = rHi_r;
         RD_RLO:    readByte = rLo_r;
         RW_OFFSET: readByte = offset_r;
         RD_MFR_ID: readByte = MFR_ID;
         RD_REV:    readByte = REV_ID;
         default:   readByte = 8'h00;
      endcase
   end
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      byteIdx_nxt = byteIdx_r;
      sdaDrv_nxt = sdaDrv_r;
      ptr_nxt = ptr_r;
      cfg_nxt = cfg_r;
      rate_nxt = rate_r;
      lHi_nxt = lHi_r;
      lLo_nxt = lLo_r;
      rHi_nxt = rHi_r;
      rLo_nxt = rLo_r;
      offset_nxt = offset_r;
      oneShot = 1'b0;
      statusClr = 1'b0;
      // R10 R11 strap decode, latched once
      slaveAddr_nxt = slaveAddr_r;
      strapDone_nxt = 1'b1;
      if (!strapDone_r) begin
         case (strapIdx(addrStrapLow))
            3'h2:    slaveAddr_nxt = {4'h9, 3'h4 + strapIdx(addrStrapHigh)};
            3'h1:    slaveAddr_nxt = {4'h5, 3'h1 + strapIdx(addrStrapHigh)};
            default: slaveAddr_nxt = {4'h3, strapIdx(addrStrapHigh)};
         endcase
      end
      if (busStop) begin
         state_nxt = TS_IDLE;
         sdaDrv_nxt = 1'b0;
      end else if (busStart) begin
         // R18 new operation per start
         state_nxt = TS_ADDR;
         bitCnt_nxt = 4'h0;
         sdaDrv_nxt = 1'b0;
      end else begin
         case (state_r)
            // R12 shift address and direction
            TS_ADDR, TS_WRB: begin
               if (sclRise) begin
                  shift_nxt = {shift_r[6:0], serialDataLineIn};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == 4'h8) begin
                  if (state_r == TS_ADDR) begin
                     // R13 acknowledge own address
                     state_nxt = (shift_r[7:1] == slaveAddr_r) ? TS_AACK : TS_WAIT;
                     sdaDrv_nxt = (shift_r[7:1] == slaveAddr_r);
                     byteIdx_nxt = 2'h0;
                  end else begin
                     // R19 at most two write bytes
                     state_nxt = (byteIdx_r < 2'h2) ? TS_WACK : TS_WAIT;
                     sdaDrv_nxt = (byteIdx_r < 2'h2);
                     // R20 pointer then data
                     if (byteIdx_r == 2'h0) begin
                        ptr_nxt = shift_r;
                     end else if (byteIdx_r == 2'h1) begin
                        case (ptr_r)
                           // R28 reserved bits stay zero
                           WR_CONFIG: cfg_nxt = shift_r & CFG_USED;
                           WR_RATE:   rate_nxt = shift_r;
                           WR_LHI:    lHi_nxt = shift_r;
                           WR_LLO:    lLo_nxt = shift_r;
                           WR_RHI:    rHi_nxt = shift_r;
                           WR_RLO:    rLo_nxt = shift_r;
                           // R23 one-shot decode
                           WR_ONESHOT: oneShot = 1'b1;
                           RW_OFFSET: offset_nxt = shift_r;
                           default: ;
                        endcase
                     end
                  end
               end
            end
            // R14 direction selects path
            TS_AACK: if (sclFall) begin
               bitCnt_nxt = 4'h0;
               if (shift_r[0]) begin
                  state_nxt = TS_RDB;
                  shift_nxt = readByte;
                  sdaDrv_nxt = ~readByte[7];
                  statusClr = (ptr_r == RD_STATUS);
               end else begin
                  state_nxt = TS_WRB;
                  sdaDrv_nxt = 1'b0;
               end
            end
            // R15 ack then next byte
            TS_WACK: if (sclFall) begin
               state_nxt = TS_WRB;
               sdaDrv_nxt = 1'b0;
               bitCnt_nxt = 4'h0;
               byteIdx_nxt = byteIdx_r + 2'h1;
            end
            TS_RDB: begin
               if (sclRise) begin
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall) begin
                  if (bitCnt_r == 4'h8) begin
                     state_nxt = TS_RACK;
                     sdaDrv_nxt = 1'b0;
                  end else begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     sdaDrv_nxt = ~shift_r[6];
                  end
               end
            end
            // R19 single read byte
            TS_RACK: if (sclRise) state_nxt = TS_WAIT;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= TS_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         byteIdx_r <= 2'h0;
         sdaDrv_r <= 1'b0;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         // R26 pointer cleared only for determinism
         ptr_r <= 8'h00;
         cfg_r <= RST_CONFIG;
         rate_r <= RST_RATE;
         lHi_r <= RST_HI;
         lLo_r <= RST_LO;
         rHi_r <= RST_HI;
         rLo_r <= RST_LO;
         offset_r <= RST_OFFSET;
         slaveAddr_r <= 7'h00;
         strapDone_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         byteIdx_r <= byteIdx_nxt;
         sdaDrv_r <= sdaDrv_nxt;
         sclPrev_r <= scl;
         sdaPrev_r <= serialDataLineIn;
         ptr_r <= ptr_nxt;
         cfg_r <= cfg_nxt;
         rate_r <= rate_nxt;
         lHi_r <= lHi_nxt;
         lLo_r <= lLo_nxt;
         rHi_r <= rHi_nxt;
         rLo_r <= rLo_nxt;
         offset_r <= offset_nxt;
         slaveAddr_r <= slaveAddr_nxt;
         strapDone_r <= strapDone_nxt;
      end
   end
   assign serialDataLineOut = 1'b0;
   assign serialDataLineOeN = ~sdaDrv_r;
   // R01 R02 config or pin standby
   assign running  = ~cfg_r[CFG_STANDBY_PIN_N] & standbyPinN;
   assign baseTick = (baseCnt_r == 23'(BaseCyc - 1));
   // R09 R27 one-shot or periodic conversion
   assign convGo = (running & baseTick & (periodCnt_r == (PERIOD_MAX >> rate_r[2:0])))
                 | (oneShot & cfg_r[CFG_STANDBY_PIN_N] & standbyPinN);
   // R08 signed remote offset
   assign newRemote = remoteTemp + offset_r;
   // R07 strict comparisons
   assign tripNew = {$signed(localTemp) > $signed(lHi_r), $signed(localTemp) < $signed(lLo_r),
                     $signed(newRemote) > $signed(rHi_r), $signed(newRemote) < $signed(rLo_r),
                     sensorOpen};
   assign tripCur = {$signed(localVal_r) > $signed(lHi_r), $signed(localVal_r) < $signed(lLo_r),
                     $signed(remoteVal_r) > $signed(rHi_r), $signed(remoteVal_r) < $signed(rLo_r),
                     flags_r[0] & sensorOpen};
   always_comb begin
      // R05 rate divider
      baseCnt_nxt = (baseTick || !running) ? 23'h0 : baseCnt_r + 23'h1;
      periodCnt_nxt = periodCnt_r;
      if (!running || convGo) begin
         periodCnt_nxt = 7'h00;
      end else if (baseTick) begin
         periodCnt_nxt = periodCnt_r + 7'h01;
      end
      // R03 values frozen outside conversions
      localVal_nxt = convGo ? localTemp : localVal_r;
      remoteVal_nxt = convGo ? newRemote : remoteVal_r;
      // Set wins over a status-read clear; live trips keep their flag.
      flags_nxt = (statusClr ? (flags_r & tripCur) : flags_r) | (convGo ? tripNew : 5'h00);
      // R04 R24 R25 mask gates flag alarm
      alarmOeN_nxt = ~((|flags_nxt) & ~cfg_nxt[CFG_MASK]);
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baseCnt_r <= 23'h0;
         periodCnt_r <= 7'h00;
         localVal_r <= RST_VALUE;
         remoteVal_r <= RST_VALUE;
         flags_r <= 5'h00;
         alarmOeN_r <= 1'b1;
      end else begin
         baseCnt_r <= baseCnt_nxt;
         periodCnt_r <= periodCnt_nxt;
         localVal_r <= localVal_nxt;
         remoteVal_r <= remoteVal_nxt;
         flags_r <= flags_nxt;
         alarmOeN_r <= alarmOeN_nxt;
      end
   end
   assign alarmOut = 1'b0;
   assign alarmOeN = alarmOeN_r;
   standby_pin_n_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R03
      !running && !oneShot |=> $stable(localVal_r) && $stable(remoteVal_r))
      else $error("value changed in standby");
   pin_standby_pin_n_a: assert property (@(posedge clk) disable iff (!resetn) // R02
      !standbyPinN |-> !convGo) else $error("conversion with standby pin low");
   mask_gate_a: assert property (@(posedge clk) disable iff (!resetn) // R24
      cfg_r[CFG_MASK] && $past(cfg_r[CFG_MASK]) |-> alarmOeN) else $error("masked alarm driven");
   alarm_flag_a: assert property (@(posedge clk) disable iff (!resetn) // R25
      (|flags_r) && !cfg_r[CFG_MASK] |-> !alarmOeN) else $error("alarm missing");
   cfg_resv_a: assert property (@(posedge clk) disable iff (!resetn) // R28
      cfg_r[5:0] == 6'h00) else $error("reserved config bits set");
   addr_nack_a: assert property (@(posedge clk) disable iff (!resetn) // R13
      state_r == TS_ADDR && sclFall && bitCnt_r == 4'h8 && shift_r[7:1] != slaveAddr_r
      |=> state_r == TS_WAIT && serialDataLineOeN) else $error("foreign address acked");
   offset_add_a: assert property (@(posedge clk) disable iff (!resetn) // R08
      convGo |=> remoteVal_r == 8'($past(remoteTemp) + $past(offset_r)))
      else $error("offset not applied");
   strap_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R11
      strapDone_r |=> $stable(slaveAddr_r)) else $error("address changed after latch");
   ptr_load_a: assert property (@(posedge clk) disable iff (!resetn) // R20
      state_r == TS_WRB && byteIdx_r == 2'h0 && sclFall && bitCnt_r == 4'h8
      |=> ptr_r == $past(shift_r)) else $error("pointer not loaded");
endmodule : tms_monitor

// ### verilog/tms_pkg.sv
// Purpose: Shared constants of the temperature monitor register and serial-bus slave.
// Assumes: 50 MHz system clock.
// Notes:   Register addresses are the pointer values used on the serial bus.
package tms_pkg;
   // Read addresses.
   localparam logic [7:0] RD_LOCAL   = 8'h00;
   localparam logic [7:0] RD_REMOTE  = 8'h01;
   localparam logic [7:0] RD_STATUS  = 8'h02;
   localparam logic [7:0] RD_CONFIG  = 8'h03;
   localparam logic [7:0] RD_RATE    = 8'h04;
   localparam logic [7:0] RD_LHI     = 8'h05;
   localparam logic [7:0] RD_LLO     = 8'h06;
   localparam logic [7:0] RD_RHI     = 8'h07;
   localparam logic [7:0] RD_RLO     = 8'h08;
   localparam logic [7:0] RD_MFR_ID  = 8'hfe;
   localparam logic [7:0] RD_REV     = 8'hff;
   // Write addresses.
   localparam logic [7:0] WR_CONFIG  = 8'h09;
   localparam logic [7:0] WR_RATE    = 8'h0a;
   localparam logic [7:0] WR_LHI     = 8'h0b;
   localparam logic [7:0] WR_LLO     = 8'h0c;
   localparam logic [7:0] WR_RHI     = 8'h0d;
   localparam logic [7:0] WR_RLO     = 8'h0e;
   localparam logic [7:0] WR_ONESHOT = 8'h0f;
   localparam logic [7:0] RW_OFFSET  = 8'h11;
   // Values after reset.
   localparam logic [7:0] RST_VALUE  = 8'h80;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_RATE   = 8'h02;
   localparam logic [7:0] RST_HI     = 8'h7f;
   localparam logic [7:0] RST_LO     = 8'hc9;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   // Identity codes; both values are arbitrary.
   localparam logic [7:0] MFR_ID     = 8'h5a;
   localparam logic [7:0] REV_ID     = 8'h17;
   // Configuration fields.
   localparam int         CFG_MASK   = 7;
   localparam int         CFG_STANDBY_PIN_N   = 6;
   localparam logic [7:0] CFG_USED   = 8'hc0;
   // Three-level strap encodings.
   localparam logic [1:0] STRAP_LOW  = 2'h0;
   localparam logic [1:0] STRAP_OPEN = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;
   // Fastest conversion period and its cycle count.
   localparam int         CLK_KHZ    = 50000;
   localparam int         BASE_MS    = 125;
   localparam int         BASE_CYC   = CLK_KHZ * BASE_MS;
   localparam logic [6:0] PERIOD_MAX = 7'h7f;
endpackage : tms_pkg

// ### dv/tms_bus_host.sv
// Purpose: Bus master model that drives the serial clock and data lines.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes:   Every drive step lasts four system clocks; a bit holds the clock low for eight.
`timescale 1ns/10ps
module tms_bus_host (
   // System clock.
   input  wire logic clk,
   // Serial bus.
   output logic      scl,
   output logic      sdaDrv,
   input  wire logic sda
);
   initial begin
      scl    = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic drive(input logic c, input logic d);
      scl    = c;
      sdaDrv = d;
      repeat (4) @(posedge clk);
      #1;
   endtask : drive
   task automatic startCond();
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
      drive(1'b0, 1'b0);
   endtask : startCond
   task automatic stopCond();
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
   endtask : stopCond
   task automatic bitXfer(input logic b, output logic seen);
      drive(1'b0, sdaDrv);
      drive(1'b0, b);
      drive(1'b1, b);
      seen = sda;
   endtask : bitXfer
   task automatic xferByte(input logic [7:0] d, output logic [7:0] got, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(d[i], got[i]);
      end
      bitXfer(1'b1, s);
      ack = ~s;
   endtask : xferByte
endmodule : tms_bus_host

// ### dv/tms_monitor_tb_top.sv
// Purpose: Self-checking bench for the temperature monitor registers and bus slave.
// Assumes: The host model drives the bus; the data line has a pull-up.
// Notes:   A short base period keeps conversion timing checks fast.
`timescale 1ns/10ps
module tms_monitor_tb_top;
   import tms_pkg::*;
   localparam int BaseCycSim = 4;
   logic       clk, resetn, scl, sdaDrv, sdaOutDev, sdaOeN, ack;
   logic       standbyPinN, sensorOpen, alarmOut, alarmOeN;
   logic [1:0] addrStrapLow, addrStrapHigh;
   logic [7:0] localTemp, remoteTemp, rd;
   logic [6:0] devAddr;
   int         mismatches, checked, p, n;
   wire logic  sda;
   logic [7:0] ptrTbl [7] = '{RD_CONFIG, RD_RATE, RD_LHI, RD_LLO, RD_RHI, RD_RLO, RW_OFFSET};
   logic [7:0] expTbl [7] = '{RST_CONFIG, RST_RATE, RST_HI, RST_LO, RST_HI, RST_LO, RST_OFFSET};
   logic [7:0] offTbl [5] = '{8'hfc, 8'hff, 8'h00, 8'h01, 8'h04};
   assign sda = sdaDrv & (sdaOeN | sdaOutDev);
   tms_monitor #(.BaseCyc(BaseCycSim)) i_dut (
      .clk(clk), .resetn(resetn), .scl(scl), .serialDataLineIn(sda),
      .serialDataLineOut(sdaOutDev), .serialDataLineOeN(sdaOeN),
      .addrStrapLow(addrStrapLow), .addrStrapHigh(addrStrapHigh), .standbyPinN(standbyPinN),
      .localTemp(localTemp), .remoteTemp(remoteTemp), .sensorOpen(sensorOpen),
      .alarmOut(alarmOut), .alarmOeN(alarmOeN)
   );
   tms_bus_host i_host (.clk(clk), .scl(scl), .sdaDrv(sdaDrv), .sda(sda));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic regWrite(input logic [7:0] ptr, input logic [7:0] data, input logic two);
      i_host.startCond();
      i_host.xferByte({devAddr, 1'b0}, rd, ack);
      check("address ack", {7'h00, ack}, 8'h01);
      i_host.xferByte(ptr, rd, ack);
      check("pointer ack", {7'h00, ack}, 8'h01);
      if (two) begin
         i_host.xferByte(data, rd, ack);
         check("data ack", {7'h00, ack}, 8'h01);
      end
      i_host.stopCond();
   endtask : regWrite
   task automatic regRead(input logic [7:0] ptr, input logic [7:0] exp, input string what,
                          input logic setPtr);
      if (setPtr) begin
         regWrite(ptr, 8'h00, 1'b0);
      end
      i_host.startCond();
      i_host.xferByte({devAddr, 1'b1}, rd, ack);
      check("read address ack", {7'h00, ack}, 8'h01);
      i_host.xferByte(8'hff, rd, ack);
      i_host.stopCond();
      check(what, rd, exp);
   endtask : regRead
   task automatic doReset();
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      resetn = 1'b1;
      #40;
   endtask : doReset
   task automatic end_sim();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      resetn = 1'b0;
      standbyPinN = 1'b1;
      sensorOpen = 1'b0;
      localTemp = 8'h20;
      remoteTemp = 8'h12;
      addrStrapLow = 2'h0;
      addrStrapHigh = 2'h0;
      devAddr = 7'h18;
      mismatches = 0;
      checked = 0;
      for (int a0 = 0; a0 < 3; a0++) begin
         for (int a1 = 0; a1 < 3; a1++) begin
            addrStrapLow = 2'(a0);
            addrStrapHigh = 2'(a1);
            doReset();
            addrStrapLow = 2'((a0 + 1) % 3);
            addrStrapHigh = 2'((a1 + 2) % 3);
            devAddr = ((a0 == 0) ? 7'h18 : (a0 == 1) ? 7'h29 : 7'h4c) + 7'(a1);
            regWrite(RD_CONFIG, 8'h00, 1'b0);
            i_host.startCond();
            i_host.xferByte({devAddr ^ 7'h40, 1'b0}, rd, ack);
            i_host.stopCond();
            check("foreign address ack", {7'h00, ack}, 8'h00);
         end
      end
      for (int i = 0; i < 7; i++) begin
         regRead(ptrTbl[i], expTbl[i], "reset value", 1'b1);
      end
      regWrite(WR_CONFIG, 8'h3f, 1'b1);
      regRead(RD_CONFIG, 8'h00, "reserved config", 1'b1);
      regWrite(WR_LHI, 8'h50, 1'b1);
      regRead(WR_LHI, 8'h00, "write address read", 1'b1);
      regRead(RD_LHI, 8'h50, "high limit", 1'b1);
      regRead(RD_LHI, 8'h50, "repeat read", 1'b0);
      i_host.startCond();
      i_host.xferByte({devAddr, 1'b0}, rd, ack);
      i_host.xferByte(WR_LLO, rd, ack);
      i_host.xferByte(8'h10, rd, ack);
      i_host.xferByte(8'h33, rd, ack);
      i_host.stopCond();
      check("third byte ack", {7'h00, ack}, 8'h00);
      regRead(RD_LLO, 8'h10, "low limit", 1'b1);
      regWrite(WR_RATE, 8'h07, 1'b1);
      for (int i = 0; i < 5; i++) begin
         regWrite(RW_OFFSET, offTbl[i], 1'b1);
         regRead(RD_REMOTE, 8'h12 + offTbl[i], "offset remote", 1'b1);
      end
      localTemp = 8'h50;
      #200;
      regRead(RD_STATUS, 8'h00, "equal to high limit", 1'b1);
      localTemp = 8'h51;
      #200;
      check("alarm on", {7'h00, alarmOeN}, 8'h00);
      check("alarm drive level", {7'h00, alarmOut}, 8'h00);
      regWrite(WR_CONFIG, 8'h80, 1'b1);
      check("alarm masked", {7'h00, alarmOeN}, 8'h01);
      regWrite(WR_CONFIG, 8'h00, 1'b1);
      check("alarm unmasked", {7'h00, alarmOeN}, 8'h00);
      localTemp = 8'h0f;
      #200;
      regRead(RD_STATUS, 8'h60, "both flags", 1'b1);
      localTemp = 8'h10;
      #200;
      regRead(RD_STATUS, 8'h20, "low flag", 1'b0);
      regRead(RD_STATUS, 8'h00, "flags clear", 1'b0);
      check("alarm off", {7'h00, alarmOeN}, 8'h01);
      localTemp = 8'h20;
      regWrite(WR_CONFIG, 8'h40, 1'b1);
      localTemp = 8'h33;
      regRead(RD_LOCAL, 8'h20, "held in standby", 1'b1);
      regWrite(WR_ONESHOT, 8'h5a, 1'b1);
      regRead(RD_LOCAL, 8'h33, "single conversion", 1'b1);
      regRead(RD_CONFIG, 8'h40, "back in standby", 1'b1);
      regWrite(WR_CONFIG, 8'h00, 1'b1);
      standbyPinN = 1'b0;
      localTemp = 8'h44;
      regWrite(WR_ONESHOT, 8'h00, 1'b1);
      regRead(RD_LOCAL, 8'h33, "pin standby", 1'b1);
      standbyPinN = 1'b1;
      regRead(RD_LOCAL, 8'h44, "running again", 1'b1);
      for (int r = 0; r < 8; r++) begin
         p = BaseCycSim << (7 - r);
         standbyPinN = 1'b0;
         regWrite(WR_RATE, 8'(r), 1'b1);
         regRead(RD_RATE, 8'(r), "rate code", 1'b1);
         regRead(RD_STATUS, (r == 0) ? 8'h00 : 8'h40, "status before", 1'b1);
         check("alarm cleared", {7'h00, alarmOeN}, 8'h01);
         localTemp = 8'h60;
         standbyPinN = 1'b1;
         n = 0;
         while (alarmOeN !== 1'b0 && n < 1100) begin
            @(posedge clk);
            #1;
            n++;
         end
         check("alarm within period", {7'h00, alarmOeN}, 8'h00);
         // Only the conversion exactly one period later may catch the marker value.
         localTemp = 8'h20;
         repeat (p - 1) @(posedge clk);
         #1;
         localTemp = 8'h21 + 8'(r);
         @(posedge clk);
         #1;
         standbyPinN = 1'b0;
         regRead(RD_LOCAL, 8'h21 + 8'(r), "conversion period", 1'b1);
      end
      standbyPinN = 1'b1;
      end_sim();
   end
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      $display("watchdog expired");
      end_sim();
   end
endmodule : tms_monitor_tb_top
